// >>> hdl/cantq_pkg.sv
// constants, register map and types for the can transmit queue and error flags block
package cantq_pkg;
  // ==========================================================
  // sizes
  localparam int NBUF = 3;
  localparam int BUF_BYTES = 14;
  localparam int BUF_WORDS = 4;
  localparam int NRXBUF = 2;
  // ==========================================================
  // register byte offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_FLAGS = 8'h04;
  localparam logic [7:0] A_ERRCNT = 8'h08;
  localparam logic [7:0] A_RXFULL = 8'h0C;
  localparam logic [7:0] A_TXCON0 = 8'h10;
  localparam logic [7:0] A_DATA0 = 8'h40;
  localparam logic [7:0] DATA_SPAN = 8'h30;
  // ==========================================================
  // field positions
  localparam int CTRL_TX_INTERRUPT_ENABLE_LSB = 0;
  localparam int CTRL_ABORT_ALL_REQUEST = 12;
  localparam int TXC_PRI_LSB = 0;
  localparam int TXC_REQ = 3;
  localparam int TXC_ERR = 4;
  localparam int TXC_LARB = 5;
  localparam int TXC_ABT = 6;
  localparam int F_TXIF_LSB = 0;
  localparam int F_ERROR_SUMMARY_FLAG = 5;
  localparam int F_IVR = 7;
  localparam int F_RECEIVE_WARNING_FLAG = 9;
  localparam int F_TX_WARNING_FLAG = 10;
  localparam int F_RECEIVE_PASSIVE_FLAG = 11;
  localparam int F_OVR_LSB = 14;
  localparam int ERR_REC_LSB = 0;
  localparam int ERR_TEC_LSB = 8;
  // ==========================================================
  // limits and masks
  localparam logic [7:0] RX_WARN_LIMIT = 8'h60;
  localparam logic [7:0] RX_PASSIVE_LIMIT = 8'h7F;
  localparam logic [7:0] TX_WARN_LIMIT = 8'h60;
  localparam logic [7:0] CNT_MAX = 8'hFF;
  localparam logic [31:0] LAST_WORD_MASK = 32'h0000FFFF;
  // ==========================================================
  // transmit sequencer states
  typedef enum logic [0:0] {
    TX_IDLE = 1'b0,
    TX_ACTIVE = 1'b1
  } cantq_tx_st_t;
endpackage : cantq_pkg

// >>> hdl/cantq_core.sv
// can transmit queue, abort handling, error counters and event flags
`timescale 1ns/100ps
module cantq_core
  import cantq_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic bus_idle,
  input wire logic tx_ok,
  input wire logic tx_arb_lost,
  input wire logic tx_ack_err,
  input wire logic tx_form_err,
  input wire logic tx_bit_err,
  input wire logic [3:0] tx_rd_addr,
  output logic tx_start,
  output logic [1:0] tx_sel,
  output logic tx_busy,
  output logic [7:0] tx_rd_byte,
  input wire logic rx_err_inc,
  input wire logic rx_ok_dec,
  input wire logic rx_msg_end,
  input wire logic rx_msg_err,
  input wire logic rx_store,
  input wire logic rx_store_buf,
  output logic rx_passive
);
  // ==========================================================
  // state
  typedef struct packed {
    logic [NBUF*BUF_WORDS-1:0][31:0] mem;
    logic [NBUF-1:0][1:0] pri;
    logic [NBUF-1:0] req;
    logic [NBUF-1:0] terr;
    logic [NBUF-1:0] larb;
    logic [NBUF-1:0] abt;
    logic [NBUF-1:0] txif;
    logic [NBUF-1:0] tx_interrupt_enable;
    logic abort_all_request;
    logic error_summary_flag;
    logic ivr;
    logic [NRXBUF-1:0] rxfull;
    logic [NRXBUF-1:0] ovr;
    logic [7:0] rec;
    logic [7:0] tec;
    cantq_tx_st_t st;
    logic [1:0] sel;
    logic start;
    logic ack;
    logic [31:0] rdata;
    logic [7:0] rbyte;
  } cantq_state_t;

  cantq_state_t st_ff;
  cantq_state_t nxt_st;
  logic acc;
  logic do_wr;

  // slave answers one cycle after the request; a write lands on the releasing edge
  assign acc = avs_read | avs_write;
  assign do_wr = avs_write & st_ff.ack;
  assign avs_waitrequest = acc & ~st_ff.ack;
  assign avs_readdata = st_ff.rdata;
  assign tx_start = st_ff.start;
  assign tx_sel = st_ff.sel;
  assign tx_busy = (st_ff.st == TX_ACTIVE);
  assign tx_rd_byte = st_ff.rbyte;
  assign rx_passive = (st_ff.rec > RX_PASSIVE_LIMIT);

  // ==========================================================
  // next state
  always_comb begin
    logic [31:0] rw;
    logic [31:0] bmask;
    logic [31:0] clr;
    logic [7:0] dofs;
    logic [3:0] widx;
    logic dhit;
    logic found;
    logic [1:0] bpri;
    logic [1:0] bsel;
    logic [1:0] nerr;
    logic [8:0] tsum;
    rw = '0;
    bmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
             {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    clr = avs_writedata & bmask;
    dofs = avs_address - A_DATA0;
    widx = dofs[5:2];
    dhit = (avs_address >= A_DATA0) && (dofs < DATA_SPAN);
    found = 1'b0;
    bpri = '0;
    bsel = '0;
    nerr = 2'({1'b0, tx_ack_err} + {1'b0, tx_form_err} + {1'b0, tx_bit_err});
    tsum = {1'b0, st_ff.tec} + {7'h00, nerr};
    nxt_st = st_ff;
    nxt_st.start = 1'b0;
    nxt_st.ack = acc & ~st_ff.ack;

    // ========================================================
    // register read
    if (avs_address == A_CTRL) begin
      rw[CTRL_TX_INTERRUPT_ENABLE_LSB +: NBUF] = st_ff.tx_interrupt_enable;
      rw[CTRL_ABORT_ALL_REQUEST] = st_ff.abort_all_request;
    end else if (avs_address == A_FLAGS) begin
      rw[F_TXIF_LSB +: NBUF] = st_ff.txif;
      rw[F_ERROR_SUMMARY_FLAG] = st_ff.error_summary_flag;
      rw[F_IVR] = st_ff.ivr;
      rw[F_RECEIVE_WARNING_FLAG] = (st_ff.rec >= RX_WARN_LIMIT);
      rw[F_TX_WARNING_FLAG] = (st_ff.tec > TX_WARN_LIMIT);
      rw[F_RECEIVE_PASSIVE_FLAG] = (st_ff.rec > RX_PASSIVE_LIMIT);
      rw[F_OVR_LSB +: NRXBUF] = st_ff.ovr;
    end else if (avs_address == A_ERRCNT) begin
      rw[ERR_REC_LSB +: 8] = st_ff.rec;
      rw[ERR_TEC_LSB +: 8] = st_ff.tec;
    end else if (avs_address == A_RXFULL) begin
      rw[NRXBUF-1:0] = st_ff.rxfull;
    end else if (dhit) begin
      rw = st_ff.mem[widx];
    end else begin
      for (int i = 0; i < NBUF; i++) begin
        if (avs_address == A_TXCON0 + 8'(4 * i)) begin
          rw[TXC_PRI_LSB +: 2] = st_ff.pri[i];
          rw[TXC_REQ] = st_ff.req[i];
          rw[TXC_ERR] = st_ff.terr[i];
          rw[TXC_LARB] = st_ff.larb[i];
          rw[TXC_ABT] = st_ff.abt[i];
        end
      end
    end
    if (acc && !st_ff.ack) begin
      nxt_st.rdata = rw;
    end

    // ========================================================
    // register write; hardware events below override so a set wins
    if (do_wr) begin
      if (avs_address == A_CTRL) begin
        if (avs_byteenable[0]) begin
          nxt_st.tx_interrupt_enable = avs_writedata[CTRL_TX_INTERRUPT_ENABLE_LSB +: NBUF];
        end
        if (avs_byteenable[1] && avs_writedata[CTRL_ABORT_ALL_REQUEST]) begin
          nxt_st.abort_all_request = 1'b1;
        end
      end else if (avs_address == A_FLAGS) begin
        nxt_st.txif = st_ff.txif & ~clr[F_TXIF_LSB +: NBUF];
        nxt_st.error_summary_flag = st_ff.error_summary_flag & ~clr[F_ERROR_SUMMARY_FLAG];
        nxt_st.ivr = st_ff.ivr & ~clr[F_IVR];
        nxt_st.ovr = st_ff.ovr & ~clr[F_OVR_LSB +: NRXBUF];
      end else if (avs_address == A_RXFULL) begin
        nxt_st.rxfull = st_ff.rxfull & ~clr[NRXBUF-1:0];
      end else if (dhit) begin
        if (widx[1:0] == 2'h3) begin
          bmask = bmask & LAST_WORD_MASK;
        end
        nxt_st.mem[widx] = (st_ff.mem[widx] & ~bmask) | (avs_writedata & bmask);
      end else begin
        for (int i = 0; i < NBUF; i++) begin
          if (avs_address == A_TXCON0 + 8'(4 * i) && avs_byteenable[0]) begin
            nxt_st.pri[i] = avs_writedata[TXC_PRI_LSB +: 2];
            if (avs_writedata[TXC_REQ] && !st_ff.req[i]) begin
              nxt_st.terr[i] = 1'b0;
              nxt_st.larb[i] = 1'b0;
              nxt_st.abt[i] = 1'b0;
            end
            nxt_st.req[i] = avs_writedata[TXC_REQ];
          end
        end
      end
    end

    // ========================================================
    // abort-all
    // abort buffers not on the bus
    if (st_ff.abort_all_request) begin
      for (int i = 0; i < NBUF; i++) begin
        if (nxt_st.req[i] && !(st_ff.st == TX_ACTIVE && st_ff.sel == 2'(i))) begin
          nxt_st.req[i] = 1'b0;
          nxt_st.abt[i] = 1'b1;
        end
      end
      if (st_ff.st == TX_IDLE && st_ff.req == '0) begin
        nxt_st.abort_all_request = 1'b0;
      end
    end

    // ========================================================
    // transmit sequencer
    unique case (st_ff.st)
      TX_IDLE: begin
        // highest priority, highest index on ties
        for (int i = 0; i < NBUF; i++) begin
          if (st_ff.req[i] && (!found || st_ff.pri[i] >= bpri)) begin
            found = 1'b1;
            bpri = st_ff.pri[i];
            bsel = 2'(i);
          end
        end
        // decide from registered state at frame start
        if (bus_idle && !st_ff.abort_all_request && found) begin
          nxt_st.st = TX_ACTIVE;
          nxt_st.sel = bsel;
          nxt_st.start = 1'b1;
        end
      end
      TX_ACTIVE: begin
        if (tx_ok) begin
          // success dequeues, flag gated by enable
          nxt_st.req[st_ff.sel] = 1'b0;
          if (st_ff.tx_interrupt_enable[st_ff.sel]) begin
            nxt_st.txif[st_ff.sel] = 1'b1;
          end
          if (st_ff.tec != 8'h00) begin
            nxt_st.tec = st_ff.tec - 8'h01;
          end
          nxt_st.st = TX_IDLE;
        end else if (nerr != 2'h0 || tx_arb_lost) begin
          if (nerr != 2'h0) begin
            nxt_st.terr[st_ff.sel] = 1'b1;
            nxt_st.tec = (tsum > {1'b0, CNT_MAX}) ? CNT_MAX : tsum[7:0];
          end else begin
            nxt_st.larb[st_ff.sel] = 1'b1;
          end
          // failed attempt may now be aborted
          if (st_ff.abort_all_request) begin
            nxt_st.req[st_ff.sel] = 1'b0;
            nxt_st.abt[st_ff.sel] = 1'b1;
          end
          nxt_st.st = TX_IDLE;
        end
      end
    endcase
    if (nxt_st.tec > TX_WARN_LIMIT && st_ff.tec <= TX_WARN_LIMIT) begin
      nxt_st.error_summary_flag = 1'b1;
    end

    // ========================================================
    // receive side
    // counted receive errors
    if (rx_err_inc) begin
      nxt_st.rec = (st_ff.rec == CNT_MAX) ? CNT_MAX : st_ff.rec + 8'h01;
      nxt_st.error_summary_flag = 1'b1;
    end else if (rx_ok_dec && st_ff.rec != 8'h00) begin
      nxt_st.rec = st_ff.rec - 8'h01;
    end
    if (rx_msg_end && rx_msg_err) begin
      nxt_st.ivr = 1'b1;
      nxt_st.error_summary_flag = 1'b1;
    end
    if (rx_store) begin
      if (st_ff.rxfull[rx_store_buf]) begin
        nxt_st.ovr[rx_store_buf] = 1'b1;
        nxt_st.error_summary_flag = 1'b1;
      end else begin
        nxt_st.rxfull[rx_store_buf] = 1'b1;
      end
    end

    // engine reads payload of the selected buffer one cycle later
    nxt_st.rbyte = st_ff.mem[{st_ff.sel, tx_rd_addr[3:2]}][{tx_rd_addr[1:0], 3'h0} +: 8];
  end

  // ==========================================================
  // registers
  always_ff @(posedge clk) begin
    if (!resetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  for (genvar gi = 0; gi < NBUF; gi++) begin : g_chk
    // fresh request carries no old flags
    a_req_clr_flags: assert property (
      $rose(st_ff.req[gi]) |-> !st_ff.terr[gi] && !st_ff.larb[gi] && !st_ff.abt[gi])
      else $error("request set with stale flags");
    // nobody better was pending at start
    a_start_best_pri: assert property (
      tx_start && !$past(do_wr) && st_ff.req[gi] |->
        (st_ff.pri[gi] < st_ff.pri[tx_sel]) ||
        (st_ff.pri[gi] == st_ff.pri[tx_sel] && 2'(gi) <= tx_sel))
      else $error("start chose a lower priority buffer");
  end

  // start only from idle with a free bus
  a_start_on_idle: assert property (
    tx_start |-> $past(bus_idle) && $past(st_ff.st) == TX_IDLE && tx_busy)
    else $error("start without free bus");
  // queueing does not start at once
  a_req_no_instant: assert property (
    do_wr && !tx_busy && st_ff.req == '0 |=> !tx_start)
    else $error("write started a frame directly");
  a_ok_clears_req: assert property (
    tx_busy && tx_ok && !do_wr |=> !st_ff.req[$past(st_ff.sel)] && !tx_busy)
    else $error("request kept after success");
  // arbitration loss keeps request and no event flag
  a_arb_keeps_req: assert property (
    tx_busy && tx_arb_lost && !tx_ok && !tx_ack_err && !tx_form_err && !tx_bit_err
      && !st_ff.abort_all_request && !do_wr && st_ff.req[st_ff.sel] |=>
      st_ff.larb[st_ff.sel] && st_ff.req[st_ff.sel] && $stable(st_ff.txif))
    else $error("arbitration loss handled wrong");
  a_err_counts: assert property (
    tx_busy && tx_bit_err && !tx_ack_err && !tx_form_err && !tx_ok
      && st_ff.tec != CNT_MAX |=> st_ff.tec == $past(st_ff.tec) + 8'h01 ##0 st_ff.terr[st_ff.sel])
    else $error("transmit error count not advanced");
  a_tx_warn: assert property (
    st_ff.tec > TX_WARN_LIMIT && $past(st_ff.tec) <= TX_WARN_LIMIT |-> st_ff.error_summary_flag)
    else $error("summary flag missing on warning");
  a_overrun: assert property (
    rx_store && st_ff.rxfull[rx_store_buf] |=> st_ff.ovr[$past(rx_store_buf)] && st_ff.error_summary_flag)
    else $error("overrun not flagged");
  a_invalid_msg: assert property (
    rx_msg_end && rx_msg_err |=> st_ff.ivr && st_ff.error_summary_flag)
    else $error("invalid message not flagged");
  // abort-all empties the queue when idle
  a_abort_all: assert property (
    st_ff.abort_all_request && !tx_busy && !do_wr |=> st_ff.req == '0 ##1 !st_ff.abort_all_request)
    else $error("abort-all left pending buffers");
  a_rx_passive: assert property (
    rx_err_inc && st_ff.rec == RX_PASSIVE_LIMIT |=> rx_passive)
    else $error("error passive not entered");

  c_start: cover property (tx_start);
  c_success: cover property (tx_busy && tx_ok);
  c_arb_lost: cover property (tx_busy && tx_arb_lost ##[1:20] tx_start);
  c_abort: cover property (st_ff.abort_all_request ##1 !st_ff.abort_all_request);
endmodule : cantq_core

// >>> bench/cantq_bus_model.sv
// far-side can bit engine model for the transmit queue bench
`timescale 1ns/100ps
module cantq_bus_model
  import cantq_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic tx_start,
  input wire logic tx_busy,
  input wire logic idle_en,
  input wire logic [2:0] outcome,
  input wire logic [3:0] hold,
  output logic bus_idle,
  output logic [4:0] ev,
  output logic [3:0] tx_rd_addr
);
  logic run_ff;
  logic [3:0] cnt_ff;
  // ==========
  // bus free only between frames, never during our own attempt
  assign bus_idle = idle_en & ~run_ff & ~tx_busy;
  always_ff @(posedge clk) begin
    ev <= 5'h00;
    if (!resetn) begin
      run_ff <= 1'b0;
      cnt_ff <= 4'h0;
      tx_rd_addr <= 4'h0;
    end else if (tx_start) begin
      run_ff <= 1'b1;
      cnt_ff <= hold;
      tx_rd_addr <= 4'h0;
    end else if (run_ff && cnt_ff != 4'h0) begin
      cnt_ff <= cnt_ff - 4'h1;
      tx_rd_addr <= tx_rd_addr + 4'h1;
    end else if (run_ff) begin
      ev <= 5'h01 << outcome;
      run_ff <= 1'b0;
    end
  end
endmodule : cantq_bus_model

// >>> bench/cantq_core_tb.sv
// self-checking bench for the can transmit queue and error flags block
`timescale 1ns/100ps
module cantq_core_tb
  import cantq_pkg::*;
;
  logic clk, resetn, avs_read, avs_write, avs_waitrequest, bus_idle, tx_start, tx_busy;
  logic rx_err_inc, rx_ok_dec, rx_msg_end, rx_msg_err, rx_store, rx_store_buf, rx_passive;
  logic idle_en;
  logic [7:0] avs_address, tx_rd_byte;
  logic [31:0] avs_writedata, avs_readdata, q, r;
  logic [63:0] pay;
  logic [31:0] rng = 32'h00005BD8;
  logic [3:0] avs_byteenable, tx_rd_addr, hold;
  logic [4:0] ev;
  logic [2:0] outcome, pend, tx_interrupt_enable;
  logic [1:0] tx_sel, e;
  logic [1:0] pri [3];
  logic [7:0] rst_list [8] = '{A_CTRL, A_FLAGS, A_ERRCNT, A_RXFULL, A_TXCON0, 8'h14, 8'h18, 8'h80};
  int n_mismatch, num_checks, n_start, exp_tec, ns0;

  cantq_core u_dut (.clk, .resetn, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .bus_idle, .tx_ok(ev[0]),
    .tx_arb_lost(ev[1]), .tx_ack_err(ev[2]), .tx_form_err(ev[3]), .tx_bit_err(ev[4]),
    .tx_rd_addr, .tx_start, .tx_sel, .tx_busy, .tx_rd_byte, .rx_err_inc, .rx_ok_dec,
    .rx_msg_end, .rx_msg_err, .rx_store, .rx_store_buf, .rx_passive);
  cantq_bus_model u_bus (.clk, .resetn, .tx_start, .tx_busy, .idle_en, .outcome, .hold,
    .bus_idle, .ev, .tx_rd_addr);

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(negedge clk) if (tx_start === 1'b1) n_start++;

  // ==========
  // helpers
  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction : xs

  function automatic logic [1:0] pick(input logic [2:0] p);
    logic [1:0] b;
    logic [2:0] best;
    b = 2'h0;
    best = 3'h0;
    // top level, ties to top index
    for (int i = 0; i < 3; i++) begin
      if (p[i] && {1'b1, pri[i]} >= best) begin
        b = 2'(i);
        best = {1'b1, pri[i]};
      end
    end
    return b;
  endfunction : pick

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    // waits for the answer however long; only the watchdog ends a hang
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    // slave promises exactly one wait cycle
    chk(32'(n), 32'h2);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask : bus

  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
    bus(1'b0, a, 32'h0);
    chk(q & m, x);
  endtask : rdc

  task automatic go(input logic [2:0] oc, input logic [1:0] sel, input logic [3:0] h);
    int n;
    n = 0;
    outcome <= oc;
    hold <= h;
    idle_en <= 1'b1;
    do begin
      @(negedge clk);
      n++;
    end while (tx_start !== 1'b1 && n < 50);
    chk({31'h0, tx_start}, 32'h1);
    chk({30'h0, tx_sel}, {30'h0, sel});
    @(posedge clk);
    idle_en <= 1'b0;
  endtask : go

  task automatic fin();
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (tx_busy !== 1'b0 && n < 50);
    chk({31'h0, tx_busy}, 32'h0);
    @(posedge clk);
  endtask : fin

  task automatic attempt(input logic [2:0] oc, input logic [1:0] sel);
    r = xs();
    go(oc, sel, {1'b0, r[2:0]});
    fin();
  endtask : attempt

  task automatic pulse(input int k);
    {rx_err_inc, rx_ok_dec, rx_msg_end, rx_store} <= 4'h8 >> k;
    @(posedge clk);
    {rx_err_inc, rx_ok_dec, rx_msg_end, rx_store} <= 4'h0;
    @(posedge clk);
  endtask : pulse

  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : test_done

  // ==========
  // main sequence
  initial begin
    resetn = 1'b0;
    {avs_read, avs_write, idle_en} = 3'h0;
    {rx_err_inc, rx_ok_dec, rx_msg_end, rx_store, rx_msg_err, rx_store_buf} = 6'h00;
    avs_address = 8'h00;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
    outcome = 3'h0;
    hold = 4'h0;
    exp_tec = 0;
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    bus(1'b1, 8'h80, 32'hFFFFFFFF);
    foreach (rst_list[i]) rdc(rst_list[i], 32'hFFFFFFFF, 32'h0);
    r = xs();
    bus(1'b1, A_DATA0 + 8'h2C, r);
    rdc(A_DATA0 + 8'h2C, 32'hFFFFFFFF, r & LAST_WORD_MASK);
    // random priorities and enables, each round drains the queue
    for (int k = 0; k < 4; k++) begin
      r = xs();
      tx_interrupt_enable = r[2:0];
      bus(1'b1, A_CTRL, {29'h0, tx_interrupt_enable});
      ns0 = n_start;
      for (int i = 0; i < 3; i++) begin
        pri[i] = r[4 + 2 * i +: 2];
        bus(1'b1, A_TXCON0 + 8'(4 * i), {28'h0, 2'b10, pri[i]});
      end
      chk(n_start, ns0);
      pend = 3'h7;
      for (int j = 0; j < 3; j++) begin
        e = pick(pend);
        attempt(3'h0, e);
        pend[e] = 1'b0;
      end
      for (int i = 0; i < 3; i++) rdc(A_TXCON0 + 8'(4 * i), 32'hFF, {30'h0, pri[i]});
      rdc(A_FLAGS, 32'h7, {29'h0, tx_interrupt_enable});
      bus(1'b1, A_FLAGS, 32'h7);
    end
    bus(1'b1, A_CTRL, 32'h0);
    for (int oc = 1; oc < 5; oc++) begin
      bus(1'b1, A_TXCON0, 32'h0);
      bus(1'b1, A_TXCON0, 32'h8);
      rdc(A_TXCON0, 32'hFF, 32'h8);
      attempt(3'(oc), 2'h0);
      exp_tec += (oc > 1);
      rdc(A_TXCON0, 32'hFF, (oc == 1) ? 32'h28 : 32'h18);
      rdc(A_ERRCNT, 32'hFF00, 32'(exp_tec << 8));
      rdc(A_FLAGS, 32'h27, 32'h0);
    end
    bus(1'b1, A_TXCON0, 32'h0);
    ns0 = n_start;
    idle_en <= 1'b1;
    repeat (20) @(posedge clk);
    idle_en <= 1'b0;
    chk(n_start, ns0);
    // abort-all lands while the top buffer is failing on the wire
    bus(1'b1, A_TXCON0, 32'h8);
    bus(1'b1, A_TXCON0 + 8'h4, 32'h9);
    bus(1'b1, A_TXCON0 + 8'h8, 32'hB);
    go(3'h2, 2'h2, 4'h9);
    bus(1'b1, A_CTRL, 32'h1000);
    fin();
    exp_tec++;
    rdc(A_TXCON0, 32'hFF, 32'h40);
    rdc(A_TXCON0 + 8'h4, 32'hFF, 32'h41);
    rdc(A_TXCON0 + 8'h8, 32'hFF, 32'h53);
    rdc(A_FLAGS, 32'h7, 32'h0);
    rdc(A_CTRL, 32'h1000, 32'h0);
    bus(1'b1, A_TXCON0, 32'h8);
    // random payload in buffer 0; the engine's last byte fetch must return it
    pay[31:0] = xs();
    pay[63:32] = xs();
    bus(1'b1, A_DATA0, pay[31:0]);
    bus(1'b1, A_DATA0 + 8'h4, pay[63:32]);
    while (exp_tec < 96) begin
      attempt(3'h2, 2'h0);
      chk({24'h0, tx_rd_byte}, {24'h0, pay[8 * hold +: 8]});
      exp_tec++;
    end
    rdc(A_ERRCNT, 32'hFF00, 32'h6000);
    rdc(A_FLAGS, 32'h420, 32'h0);
    attempt(3'h4, 2'h0);
    rdc(A_FLAGS, 32'h420, 32'h420);
    bus(1'b1, A_TXCON0, 32'h0);
    // receive side counters and flags
    bus(1'b1, A_FLAGS, 32'hFFFF);
    pulse(0);
    rdc(A_FLAGS, 32'h20, 32'h20);
    repeat (94) pulse(0);
    rdc(A_FLAGS, 32'h200, 32'h0);
    pulse(0);
    rdc(A_ERRCNT, 32'hFF, 32'h60);
    rdc(A_FLAGS, 32'h200, 32'h200);
    repeat (31) pulse(0);
    rdc(A_FLAGS, 32'h800, 32'h0);
    chk({31'h0, rx_passive}, 32'h0);
    pulse(0);
    rdc(A_FLAGS, 32'h800, 32'h800);
    chk({31'h0, rx_passive}, 32'h1);
    pulse(1);
    rdc(A_FLAGS, 32'h800, 32'h0);
    chk({31'h0, rx_passive}, 32'h0);
    pulse(2);
    rdc(A_FLAGS, 32'h80, 32'h0);
    rx_msg_err <= 1'b1;
    pulse(2);
    rdc(A_FLAGS, 32'h80, 32'h80);
    rx_store_buf <= 1'b1;
    pulse(3);
    rdc(A_FLAGS, 32'hC000, 32'h0);
    pulse(3);
    rdc(A_FLAGS, 32'hC000, 32'h8000);
    rdc(A_RXFULL, 32'h3, 32'h2);
    test_done();
  end

  // hang guard, generous against the fewer than two thousand cycles the run needs
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    test_done();
  end
endmodule : cantq_core_tb
